// >>> inc/spimc_pkg.sv
// constants and carrier types for the serial master host-side controller
package spimc_pkg;

	// ----------------------------------------------------------------
	// device register map, as seen by this controller
	// ----------------------------------------------------------------
	localparam logic [7:0] SPIMC_A_CTRL = 8'h00;	// control: bit order, auto refill
	localparam logic [7:0] SPIMC_A_CLK  = 8'h04;	// clock control: edges, polarity, source
	localparam logic [7:0] SPIMC_A_STAT = 8'h08;	// status flags (polled via irq lines)
	localparam logic [7:0] SPIMC_A_TXD  = 8'h0C;	// transmit holding register
	localparam logic [7:0] SPIMC_A_RXD  = 8'h10;	// receive holding register

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int SPIMC_CTRL_LOW_BIT_FIRST_SELECT = 0;	// low_bit_first_select
	localparam int SPIMC_CTRL_AUTO = 1;	// dma_read_autorefill
	localparam int SPIMC_CLK_TXE   = 0;	// transmit_edge_select
	localparam int SPIMC_CLK_RXE   = 1;	// receive_edge_select
	localparam int SPIMC_CLK_POL   = 2;	// clock_polarity_select
	localparam int SPIMC_CLK_SRC   = 3;	// reference select, 48 MHz or 2 MHz

	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic [7:0] SPIMC_REG_RST = 8'h00;	// reserved bits written as zero
	localparam logic [1:0] SPIMC_SETTLE  = 2'h3;	// cycles for flags to pass the synchroniser

	// per-command serial configuration
	typedef struct packed {
		logic	lsb_first;	// shift low bit first
		logic	tx_edge;	// edge that drives out bits
		logic	rx_edge;	// edge that samples in bits
		logic	pol;		// serial clock polarity
		logic	clk_src;	// reference clock select
	} spimc_cfg_t;

	// one user order
	typedef struct packed {
		logic		auto_rd;	// auto-refill receive burst
		logic [7:0]	count;		// bytes in an auto burst
		logic [7:0]	data;		// byte to send, or dummy byte
		spimc_cfg_t	cfg;		// link settings for this order
	} spimc_cmd_t;

	// register access strobe toward the device
	typedef struct packed {
		logic		wr;	// one-cycle write strobe
		logic		rd;	// one-cycle read strobe
		logic [7:0]	addr;	// register offset
		logic [7:0]	wdata;	// write data
	} spimc_bus_t;

endpackage

// >>> verilog/spimc_ctrl.sv
// host-side controller that drives the serial master through its registers
// Summary of operation
// - transfer starts only by transmit register write; in an autorefill burst the receive register read also starts the next byte
// - write transmit only when tx_buffer_empty set
// - read receive first, write, poll rx_buffer_full
// - every byte lands in receive register
// - half duplex still needs dummy byte
// - receive_edge_select must suit the slave
// - each tx_buffer_empty fetches one more byte
// - set autorefill, then write one dummy
// - only one DMA direction at once
// - long transfers are chained byte cycles
module spimc_ctrl (
	input  wire logic		ref_clk_i,	// 10 MHz controller clock
	input  wire logic		sys_rst_i,	// synchronous, active high
	input  wire logic		cmd_valid_i,	// user order offered
	input  wire spimc_pkg::spimc_cmd_t	cmd_i,		// user order
	output logic			cmd_ready_o,	// controller idle, order taken
	output logic			rsp_valid_o,	// one-cycle received byte pulse
	output logic [7:0]		rsp_data_o,	// received byte
	output spimc_pkg::spimc_bus_t	dev_bus_o,	// register strobes to device
	input  wire logic [7:0]		dev_rdata_i,	// read data, cycle after strobe
	input  wire logic		tx_empty_irq_i,	// tx_empty_irq_source line
	input  wire logic		rx_full_irq_i	// rx_full_irq_source line
);
	import spimc_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE, ST_CTRL0, ST_CLKW, ST_CLR, ST_CTRL1, ST_WAIT_TE,
		ST_WAIT_RF, ST_AOFF, ST_RDX, ST_RXWT, ST_RXCAP
	} spimc_state_t;

	spimc_state_t	state;		// sequencer state
	spimc_cmd_t	cur;		// order being served
	logic [7:0]	left;		// bytes still due in a burst
	logic [1:0]	settle;		// flag settling countdown
	logic		te_m;		// tx empty, first stage
	logic		te_s;		// tx empty, synchronised
	logic		rf_m;		// rx full, first stage
	logic		rf_s;		// rx full, synchronised
	logic		quiet;		// no strobe out and flags settled
	logic		rx_cleared;	// receive read since last transmit write
	logic		cfg_sent;	// clock settings written for this order
	logic		tx_pending;	// byte in flight, answer not yet given

	// flags only count once any strobe's effect has crossed the synchroniser
	assign quiet = (settle == 2'h0) && !dev_bus_o.wr && !dev_bus_o.rd;

	// control register image
	function automatic logic [7:0] ctrl_byte(input spimc_cfg_t c, input logic au);
		logic [7:0] v;
		v = SPIMC_REG_RST;
		v[SPIMC_CTRL_LOW_BIT_FIRST_SELECT] = c.lsb_first;
		v[SPIMC_CTRL_AUTO] = au;
		return v;
	endfunction

	// clock control register image
	function automatic logic [7:0] clk_byte(input spimc_cfg_t c);
		logic [7:0] v;
		v = SPIMC_REG_RST;
		v[SPIMC_CLK_TXE] = c.tx_edge;
		v[SPIMC_CLK_RXE] = c.rx_edge;
		v[SPIMC_CLK_POL] = c.pol;
		v[SPIMC_CLK_SRC] = c.clk_src;
		return v;
	endfunction

	// ----------------------------------------------------------------
	// flag synchronisers
	// ----------------------------------------------------------------
	// the flags come from another party, two stages before any use
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			te_m <= 1'b0;
			te_s <= 1'b0;
			rf_m <= 1'b0;
			rf_s <= 1'b0;
		end
		else
		begin
			te_m <= tx_empty_irq_i;
			te_s <= te_m;
			rf_m <= rx_full_irq_i;
			rf_s <= rf_m;
		end
	end

	// ----------------------------------------------------------------
	// settle counter
	// ----------------------------------------------------------------
	// reloads on every strobe so a stale flag is never trusted
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			settle <= 2'h0;
		else if (dev_bus_o.wr || dev_bus_o.rd)
			settle <= SPIMC_SETTLE;
		else if (settle != 2'h0)
			settle <= settle - 2'h1;
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			state       <= ST_IDLE;
			dev_bus_o   <= '0;
			cmd_ready_o <= 1'b0;
			cur         <= '0;
			left        <= 8'h00;
		end
		else
		begin
			// strobes are single-cycle pulses
			dev_bus_o.wr <= 1'b0;
			dev_bus_o.rd <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					cmd_ready_o <= 1'b1;
					if (cmd_valid_i && cmd_ready_o)
					begin
						cur         <= cmd_i;
						left        <= cmd_i.count;
						cmd_ready_o <= 1'b0;
						state       <= ST_CTRL0;
					end
				end
				// autorefill off first, so the clearing read cannot reload
				ST_CTRL0:
				begin
					dev_bus_o.wr    <= 1'b1;
					dev_bus_o.addr  <= SPIMC_A_CTRL;
					dev_bus_o.wdata <= ctrl_byte(cur.cfg, 1'b0);
					state           <= ST_CLKW;
				end
				ST_CLKW:
				begin
					dev_bus_o.wr    <= 1'b1;
					dev_bus_o.addr  <= SPIMC_A_CLK;
					dev_bus_o.wdata <= clk_byte(cur.cfg);
					state           <= ST_CLR;
				end
				// stale byte dropped so the flag means this byte
				ST_CLR:
				begin
					dev_bus_o.rd   <= 1'b1;
					dev_bus_o.addr <= SPIMC_A_RXD;
					// receive burst or plain byte, never both
					state <= cur.auto_rd ? ST_CTRL1 : ST_WAIT_TE;
				end
				ST_CTRL1:
				begin
					dev_bus_o.wr    <= 1'b1;
					dev_bus_o.addr  <= SPIMC_A_CTRL;
					dev_bus_o.wdata <= ctrl_byte(cur.cfg, 1'b1);
					state           <= ST_WAIT_TE;
				end
				// holding register must be free before the write
				ST_WAIT_TE:
				begin
					if (quiet && te_s)
					begin
						dev_bus_o.wr    <= 1'b1;
						dev_bus_o.addr  <= SPIMC_A_TXD;
						dev_bus_o.wdata <= cur.data;
						state           <= ST_WAIT_RF;
					end
				end
				// poll the full flag for the byte just clocked
				ST_WAIT_RF:
				begin
					if (quiet && rf_s)
					begin
						if (cur.auto_rd && (left <= 8'h01))
							state <= ST_AOFF;
						else
							state <= ST_RDX;
					end
				end
				// last burst byte: stop refill so no extra byte is clocked
				ST_AOFF:
				begin
					dev_bus_o.wr    <= 1'b1;
					dev_bus_o.addr  <= SPIMC_A_CTRL;
					dev_bus_o.wdata <= ctrl_byte(cur.cfg, 1'b0);
					state           <= ST_RDX;
				end
				ST_RDX:
				begin
					dev_bus_o.rd   <= 1'b1;
					dev_bus_o.addr <= SPIMC_A_RXD;
					state          <= ST_RXWT;
				end
				// device returns data one cycle after the strobe
				ST_RXWT:
					state <= ST_RXCAP;
				// in a burst the read itself reloads the dummy byte
				ST_RXCAP:
				begin
					if (cur.auto_rd && (left > 8'h01))
					begin
						left  <= left - 8'h01;
						state <= ST_WAIT_RF;
					end
					else
						state <= ST_IDLE;
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// answer toward the user
	// ----------------------------------------------------------------
	// every byte is handed on; unwanted ones are the user's to drop
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			rsp_valid_o <= 1'b0;
			rsp_data_o  <= 8'h00;
		end
		else
		begin
			rsp_valid_o <= (state == ST_RXCAP);
			if (state == ST_RXCAP)
				rsp_data_o <= dev_rdata_i;
		end
	end

	// ----------------------------------------------------------------
	// bookkeeping read only by the checks below
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			rx_cleared <= 1'b0;
			cfg_sent   <= 1'b0;
			tx_pending <= 1'b0;
		end
		else
		begin
			if (dev_bus_o.rd && dev_bus_o.addr == SPIMC_A_RXD)
				rx_cleared <= 1'b1;
			else if (dev_bus_o.wr && dev_bus_o.addr == SPIMC_A_TXD)
				rx_cleared <= 1'b0;
			if (cmd_valid_i && cmd_ready_o)
				cfg_sent <= 1'b0;
			else if (dev_bus_o.wr && dev_bus_o.addr == SPIMC_A_CLK)
				cfg_sent <= 1'b1;
			if (dev_bus_o.wr && dev_bus_o.addr == SPIMC_A_TXD)
				tx_pending <= 1'b1;
			else if (state == ST_RXCAP)
				tx_pending <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_tx_write;
		dev_bus_o.wr && dev_bus_o.addr == SPIMC_A_TXD;
	endsequence

	sequence s_rx_read;
		dev_bus_o.rd && dev_bus_o.addr == SPIMC_A_RXD;
	endsequence

	a_tx_needs_empty: assert property (s_tx_write |-> $past(te_s) && $past(settle) == 2'h0)
		else $error("transmit written while holding register busy");
	a_rx_clear_first: assert property (s_tx_write |-> rx_cleared)
		else $error("transmit written without clearing receive first");
	// the result read from ST_RDX is seen with the sequencer already waiting for its data
	a_rsp_from_read: assert property (s_rx_read ##0 state == ST_RXWT |-> ##2 rsp_valid_o)
		else $error("received byte not handed on");
	a_rsp_data: assert property (rsp_valid_o |-> rsp_data_o == $past(dev_rdata_i))
		else $error("answer differs from read data");
	// back-to-back writes are legal only to different registers
	a_one_strobe: assert property (!(dev_bus_o.wr && dev_bus_o.rd) and
		(dev_bus_o.wr |=> !dev_bus_o.wr || $changed(dev_bus_o.addr)))
		else $error("overlapping or stretched strobes");
	a_byte_chain: assert property (s_tx_write |-> !$past(tx_pending))
		else $error("second byte written before first answered");
	a_auto_only: assert property (dev_bus_o.wr && dev_bus_o.addr == SPIMC_A_CTRL
		&& dev_bus_o.wdata[SPIMC_CTRL_AUTO] |-> cur.auto_rd)
		else $error("autorefill set outside receive burst");
	a_cfg_before_tx: assert property (s_tx_write |-> cfg_sent)
		else $error("byte sent before clock settings");

endmodule

// >>> verification/spimc_dev_model.sv
// behavioural model of the serial master device and its register block
module spimc_dev_model (
	input  wire logic			ref_clk_i,	// device clock
	input  wire logic			sys_rst_i,	// main_well_reset
	input  wire spimc_pkg::spimc_bus_t	bus_i,		// register strobes
	output logic [7:0]			rdata_o,	// valid cycle after strobe
	output logic				tx_empty_o,	// tx_buffer_empty
	output logic				rx_full_o,	// rx_buffer_full
	output logic				sclk_o		// serial_clock_pin_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import spimc_pkg::*;
	logic [7:0]	ctrl;		// control register
	logic [7:0]	clk_cfg;	// clock control register
	logic [7:0]	hold;		// transmit holding register
	logic [7:0]	sh;		// transmit shift register
	logic [7:0]	rx_sh;		// receive shift register
	logic [7:0]	rx_hold;	// receive holding register
	logic [7:0]	tx_cap;		// bits seen on serial_out_line
	logic [7:0]	rx_nx;		// receive byte with this bit added
	logic		busy;		// byte being shifted
	logic [1:0]	div;		// reload down-counter
	logic [3:0]	half;		// serial clock half periods
	logic		sdo;		// serial_out_line
	int		nbytes;		// bytes shifted since reset
	logic		lsb;		// low_bit_first_select
	assign lsb = ctrl[SPIMC_CTRL_LOW_BIT_FIRST_SELECT];
	// full duplex only, so serial_out_line is never turned to input
	assign sdo = lsb ? sh[0] : sh[7];
	// far side echoes the inverse, so a stuck line cannot pass
	assign rx_nx = lsb ? {~sdo, rx_sh[7:1]} : {rx_sh[6:0], ~sdo};
	// ------------------------------------------------------------
	// registers and byte engine
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			// control, clock, flag and rx_hold registers back to default; data shifters keep their value
			ctrl <= 8'h00;
			clk_cfg <= 8'h00;
			tx_empty_o <= 1'b1;
			rx_full_o <= 1'b0;
			busy <= 1'b0;
			sclk_o <= 1'b0;
			rx_hold <= 8'h00;
			nbytes <= 0;
		end
		else
		begin
			if (bus_i.wr && bus_i.addr == SPIMC_A_CTRL)
				ctrl <= bus_i.wdata;
			if (bus_i.wr && bus_i.addr == SPIMC_A_CLK)
				clk_cfg <= bus_i.wdata;
			if (bus_i.rd)
				rdata_o <= rx_hold;
			if (!busy && !tx_empty_o)
			begin
				// free shifter takes the held byte
				sh <= hold;
				busy <= 1'b1;
				tx_empty_o <= 1'b1;
				div <= 2'h3;
				half <= 4'h0;
			end
			else if (!busy)
				sclk_o <= clk_cfg[SPIMC_CLK_POL];
			else if (div != 2'h0)
				div <= div - 2'h1;
			else
			begin
				// underflow toggles the clock
				div <= 2'h3;
				half <= half + 4'h1;
				sclk_o <= ~sclk_o;
				if (half[0])
				begin
					sh <= lsb ? sh >> 1 : sh << 1;
					rx_sh <= rx_nx;
					tx_cap <= lsb ? {sdo, tx_cap[7:1]} : {tx_cap[6:0], sdo};
				end
				if (half == 4'hF)
				begin
					// byte lands in receive register
					busy <= 1'b0;
					rx_hold <= rx_nx;
					rx_full_o <= 1'b1;
					nbytes <= nbytes + 1;
				end
			end
			if (bus_i.wr && bus_i.addr == SPIMC_A_TXD)
			begin
				hold <= bus_i.wdata;
				tx_empty_o <= 1'b0;
			end
			if (bus_i.rd && bus_i.addr == SPIMC_A_RXD)
			begin
				rx_full_o <= 1'b0;
				if (ctrl[SPIMC_CTRL_AUTO])
					tx_empty_o <= 1'b0;
			end
		end
	end
endmodule

// >>> verification/spimc_ctrl_tb.sv
// self-checking bench for the serial master host-side controller
module spimc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import spimc_pkg::*;
	logic		clk;		// 10 MHz clock
	logic		rst;		// synchronous reset
	logic		cmd_valid;	// order offered
	spimc_cmd_t	cmd;		// order
	logic		ready;		// controller idle
	logic		rsp_valid;	// received byte pulse
	logic [7:0]	rsp_data;	// received byte
	spimc_bus_t	dbus;		// register strobes
	logic [7:0]	rdata;		// device read data
	logic		empty;		// tx_buffer_empty line
	logic		full;		// rx_buffer_full line
	int		err_count;	// mismatches
	int		total_checks;	// comparisons
	spimc_ctrl DUT (.ref_clk_i(clk), .sys_rst_i(rst), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
		.cmd_ready_o(ready), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .dev_bus_o(dbus),
		.dev_rdata_i(rdata), .tx_empty_irq_i(empty), .rx_full_irq_i(full));
	spimc_dev_model dev (.ref_clk_i(clk), .sys_rst_i(rst), .bus_i(dbus), .rdata_o(rdata),
		.tx_empty_o(empty), .rx_full_o(full), .sclk_o());
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run();
		if (err_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// one order end to end, entered at a falling edge
	task automatic run_order(input logic au, input logic [7:0] cnt, input logic [7:0] d,
		input spimc_cfg_t cfg);
		int n0;
		int nexp;
		int got;
		int w;
		n0 = dev.nbytes;
		nexp = (au && cnt != 8'h00) ? int'(cnt) : 1;
		got = 0;
		w = 0;
		cmd = {au, cnt, d, cfg};
		cmd_valid = 1'b1;
		while (ready !== 1'b1 && w < 500)
		begin
			@(negedge clk);
			w++;
		end
		@(negedge clk);
		cmd_valid = 1'b0;
		while (got < nexp && w < 20000)
		begin
			@(negedge clk);
			w++;
			if (rsp_valid === 1'b1)
			begin
				got++;
				chk("rx byte", ~d, rsp_data);
			end
		end
		// quiet span shows no byte clocks without a new write
		repeat (100) @(negedge clk);
		chk("answers", 8'(nexp), 8'(got));
		chk("bytes shifted", 8'(nexp), 8'(dev.nbytes - n0));
		chk("sent byte", d, dev.tx_cap);
		chk("control reg", {7'h00, cfg.lsb_first}, dev.ctrl);
		chk("clock reg", {4'h0, cfg.clk_src, cfg.pol, cfg.rx_edge, cfg.tx_edge}, dev.clk_cfg);
	endtask
	// link settings grow one bit at a time; data runs 00 to FF
	task automatic scn_config_sweep();
		for (int i = 0; i < 6; i++)
			run_order(1'b0, 8'h00, 8'(i * 8'h33), 5'(5'h1F >> (5 - i)));
	endtask
	// auto-refill bursts: zero counts as one, then single and longer
	task automatic scn_auto_burst();
		run_order(1'b1, 8'h00, 8'hC3, 5'h10);
		run_order(1'b1, 8'h01, 8'h3C, 5'h00);
		run_order(1'b1, 8'h04, 8'hE7, 5'h1F);
	endtask
	// reset in mid byte, then a clean order must still work
	task automatic scn_mid_reset();
		cmd = {1'b0, 8'h01, 8'h3C, 5'h00};
		cmd_valid = 1'b1;
		repeat (30) @(negedge clk);
		cmd_valid = 1'b0;
		rst = 1'b1;
		repeat (3) @(negedge clk);
		chk("outputs in reset", 8'h00, {4'h0, ready, rsp_valid, dbus.wr, dbus.rd});
		rst = 1'b0;
		repeat (2) @(negedge clk);
		chk("ready after reset", 8'h01, {7'h00, ready});
		run_order(1'b0, 8'h00, 8'h96, 5'h05);
	endtask
	initial
	begin
		err_count = 0;
		total_checks = 0;
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd = '0;
		repeat (20) @(negedge clk);
		chk("outputs in reset", 8'h00, {4'h0, ready, rsp_valid, dbus.wr, dbus.rd});
		rst = 1'b0;
		scn_config_sweep();
		scn_auto_burst();
		scn_mid_reset();
		complete_run();
	end
	// watchdog: roughly ten times the expected run
	initial
	begin
		#2000000;
		err_count++;
		complete_run();
	end
endmodule
